// [src/clf_line_fill.sv]
// cache line refill engine for the instruction and data masters
`timescale 1ns/1ps
module clf_line_fill
    import clf_pkg::*;
#(
    parameter int ICACHE_BYTES = 2048,
    parameter int DCACHE_BYTES = 2048,
    parameter int D_LINE_BYTES = 32,
    parameter bit I_BURST_EN = 1'b1,
    parameter bit D_BURST_EN = 1'b1,
    parameter bit OMIT_DMASTER = 1'b0,
    parameter int ITCM_PORTS = 1,
    parameter int DTCM_PORTS = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic imiss_valid,
    input wire logic [31:0] imiss_addr,
    output logic imiss_ready,
    input wire logic dmiss_valid,
    input wire logic [31:0] dmiss_addr,
    output logic dmiss_ready,
    output logic im_read,
    output logic dm_read,
    output clf_rd_t m_rd,
    input wire logic m_wait,
    input wire logic m_rvalid,
    input wire logic [31:0] m_rdata,
    output logic m_rready,
    output logic fill_valid,
    output clf_fill_t fill,
    input wire logic fill_ready,
    output logic line_done,
    output clf_side_t line_done_side,
    output logic [CLF_TCM_MAX-1:0] itcm_en,
    output logic [CLF_TCM_MAX-1:0] dtcm_en
);
    // build-time shape of the block
    localparam bit I_PRES = (ICACHE_BYTES != 0);
    localparam bit D_PRES = (DCACHE_BYTES != 0);
    localparam bit DM_PRES = !(OMIT_DMASTER && !D_PRES);
    localparam logic [3:0] I_WORDS = 4'(CLF_I_LINE_BYTES / CLF_WORD_BYTES);
    localparam logic [3:0] D_WORDS = 4'(D_LINE_BYTES / CLF_WORD_BYTES);
    localparam bit D_BURST = D_BURST_EN && (D_LINE_BYTES > CLF_D_LINE_4);
    localparam logic [31:0] I_MASK = ~32'(CLF_I_LINE_BYTES - 1);
    localparam logic [31:0] D_MASK = ~32'(D_LINE_BYTES - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_COLLECT} clf_state_t;

    clf_state_t state_r;
    logic [2:0] ctrl_r;
    logic [31:0] reg_rdata_r;
    clf_side_t side_r;
    logic [31:0] base_r;
    logic [2:0] crit_r;
    logic burst_r;
    logic [3:0] nwords_r;
    logic [3:0] issued_r;
    logic [3:0] pushed_r;
    logic [3:0] drained_r;
    logic line_done_r;
    clf_side_t done_side_r;
    logic [2:0] prev_w_r;
    logic i_take;
    logic d_take;
    logic issue_ok;
    logic push;
    logic drain;
    logic last_drain;
    logic [2:0] issue_w;
    logic [31:0] fifo_data;
    logic [31:0] cfg_word;
    logic [31:0] status_word;

    // tightly coupled port enables, one per possible port
    for (genvar g = 0; g < CLF_TCM_MAX; g++) begin : g_tcm
        assign itcm_en[g] = (g < ITCM_PORTS);
        assign dtcm_en[g] = (g < DTCM_PORTS);
    end

    // miss acceptance, instruction side first
    assign imiss_ready = (state_r == ST_IDLE) && I_PRES &&
                         ctrl_r[CLF_CTRL_IEN];
    assign i_take = imiss_valid && imiss_ready;
    assign dmiss_ready = (state_r == ST_IDLE) && DM_PRES &&
                         ctrl_r[CLF_CTRL_DEN] && !i_take;
    assign d_take = dmiss_valid && dmiss_ready;

    // master read request
    assign issue_w = crit_r + issued_r[2:0];
    assign im_read = (state_r == ST_ISSUE) && (side_r == CLF_SIDE_I) &&
                     I_PRES;
    assign dm_read = (state_r == ST_ISSUE) && (side_r == CLF_SIDE_D) &&
                     DM_PRES;
    assign issue_ok = (im_read || dm_read) && !m_wait;

    // request fields held in flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            m_rd <= '0;
        end else if (i_take) begin
            // critical word first
            m_rd.addr <= {imiss_addr[31:2], 2'b00};
            m_rd.burstcount <= (I_BURST_EN && ctrl_r[CLF_CTRL_BURST]) ?
                               I_WORDS : 4'h1;
        end else if (d_take) begin
            // line aligned start
            m_rd.addr <= dmiss_addr & D_MASK;
            m_rd.burstcount <= (D_BURST && ctrl_r[CLF_CTRL_BURST]) ?
                               D_WORDS : 4'h1;
        end else if (issue_ok && !burst_r) begin
            // next single word, ascending and wrapping
            m_rd.addr <= base_r | {27'h0, issue_w + 3'h1, 2'b00};
        end
    end

    // refill bookkeeping captured at the miss
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            side_r <= CLF_SIDE_I;
            base_r <= '0;
            crit_r <= '0;
            burst_r <= 1'b0;
            nwords_r <= '0;
        end else if (i_take) begin
            side_r <= CLF_SIDE_I;
            base_r <= imiss_addr & I_MASK;
            crit_r <= imiss_addr[4:2];
            burst_r <= I_BURST_EN && ctrl_r[CLF_CTRL_BURST];
            nwords_r <= I_WORDS;
        end else if (d_take) begin
            side_r <= CLF_SIDE_D;
            base_r <= dmiss_addr & D_MASK;
            crit_r <= 3'h0;
            burst_r <= D_BURST && ctrl_r[CLF_CTRL_BURST];
            nwords_r <= D_WORDS;
        end
    end

    // refill sequencing
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (i_take || d_take) begin
                        state_r <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (issue_ok) begin
                        state_r <= ST_COLLECT;
                    end
                end
                ST_COLLECT: begin
                    if (last_drain) begin
                        state_r <= ST_IDLE;
                    end else if (!burst_r && (pushed_r == issued_r) &&
                                 (issued_r < nwords_r)) begin
                        state_r <= ST_ISSUE; // one word at a time
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // beat counters
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            issued_r <= '0;
            pushed_r <= '0;
            drained_r <= '0;
            prev_w_r <= '0;
        end else if (i_take || d_take) begin
            issued_r <= '0;
            pushed_r <= '0;
            drained_r <= '0;
        end else begin
            if (issue_ok) begin
                // a burst accounts for the whole line at once
                issued_r <= burst_r ? nwords_r : issued_r + 4'h1;
                prev_w_r <= m_rd.addr[4:2];
            end
            if (push) begin
                pushed_r <= pushed_r + 4'h1;
            end
            if (drain) begin
                drained_r <= drained_r + 4'h1;
            end
        end
    end

    // returned words pass through the buffer
    assign push = m_rvalid && m_rready;
    assign drain = fill_valid && fill_ready;
    assign last_drain = drain && (drained_r == nwords_r - 4'h1);
    assign fill.side = side_r;
    assign fill.idx = crit_r + drained_r[2:0];
    assign fill.data = fifo_data;

    clf_fifo #(
        .WIDTH(CLF_DATA_W),
        .DEPTH(CLF_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(m_rvalid),
        .in_ready(m_rready),
        .in_data(m_rdata),
        .out_valid(fill_valid),
        .out_ready(fill_ready),
        .out_data(fifo_data)
    );

    // line complete pulse after the last word
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            line_done_r <= 1'b0;
            done_side_r <= CLF_SIDE_I;
        end else begin
            line_done_r <= last_drain;
            if (last_drain) begin
                done_side_r <= side_r;
            end
        end
    end
    assign line_done = line_done_r;
    assign line_done_side = done_side_r;

    // register words
    assign cfg_word = {12'h0, 4'(DTCM_PORTS), 4'(ITCM_PORTS), D_WORDS,
                       2'b00, D_BURST, I_BURST_EN, DM_PRES, I_PRES,
                       D_PRES, I_PRES};
    assign status_word = {20'h0, drained_r, issued_r, 2'b00,
                          side_r == CLF_SIDE_D, state_r != ST_IDLE};

    // control register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CLF_CTRL_RST;
        end else if (reg_wr && (reg_addr == CLF_REG_CTRL)) begin
            ctrl_r <= reg_wdata[2:0];
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                CLF_REG_CTRL: reg_rdata_r <= {29'h0, ctrl_r};
                CLF_REG_STATUS: reg_rdata_r <= status_word;
                CLF_REG_CFG: reg_rdata_r <= cfg_word;
                default: reg_rdata_r <= '0;
            endcase
        end else begin
            reg_rdata_r <= '0;
        end
    end
    assign reg_rdata = reg_rdata_r;

    // checks
    a_icache_size: assert property (@(posedge mclk) disable iff (sys_rst)
        (ICACHE_BYTES == 0) || ((ICACHE_BYTES >= CLF_CACHE_MIN) &&
        (ICACHE_BYTES <= CLF_CACHE_MAX)))
        else $error("instruction cache size out of range");

    a_imaster_gone: assert property (@(posedge mclk) disable iff (sys_rst)
        !I_PRES |-> (!im_read && !imiss_ready &&
        (ITCM_PORTS >= CLF_TCM_MIN)))
        else $error("instruction master active without cache");

    a_iburst_len: assert property (@(posedge mclk) disable iff (sys_rst)
        im_read |-> (m_rd.burstcount == (burst_r ? I_WORDS : 4'h1)))
        else $error("instruction burst length wrong");

    a_iaddr_step: assert property (@(posedge mclk) disable iff (sys_rst)
        (im_read && !burst_r && issued_r != 4'h0 && prev_w_r != 3'h7)
        |-> (m_rd.addr[4:2] == prev_w_r + 3'h1))
        else $error("instruction word not ascending by four");

    a_crit_first: assert property (@(posedge mclk) disable iff (sys_rst)
        i_take |=> (im_read &&
        m_rd.addr == {$past(imiss_addr[31:2]), 2'b00}))
        else $error("critical word not fetched first");

    a_iaddr_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
        (im_read && !burst_r && issued_r != 4'h0 && prev_w_r == 3'h7)
        |-> (m_rd.addr == base_r))
        else $error("instruction refill did not wrap to line start");

    a_tcm_count: assert property (@(posedge mclk) disable iff (sys_rst)
        (ITCM_PORTS <= CLF_TCM_MAX) && (DTCM_PORTS <= CLF_TCM_MAX) &&
        ($countones(itcm_en) == ITCM_PORTS))
        else $error("tightly coupled port count out of range");

    a_dcache_size: assert property (@(posedge mclk) disable iff (sys_rst)
        ((DCACHE_BYTES == 0) || ((DCACHE_BYTES >= CLF_CACHE_MIN) &&
        (DCACHE_BYTES <= CLF_CACHE_MAX))) &&
        ((D_LINE_BYTES == CLF_D_LINE_4) || (D_LINE_BYTES == CLF_D_LINE_16)
        || (D_LINE_BYTES == CLF_D_LINE_32)))
        else $error("data cache size or line size illegal");

    a_dmaster_gone: assert property (@(posedge mclk) disable iff (sys_rst)
        !DM_PRES |-> (!dm_read && !D_PRES &&
        (DTCM_PORTS >= CLF_TCM_MIN)))
        else $error("data master removed illegally or active");

    a_dburst_len: assert property (@(posedge mclk) disable iff (sys_rst)
        dm_read |-> (m_rd.burstcount == ((D_BURST && burst_r) ?
        D_WORDS : 4'h1)))
        else $error("data burst length wrong");

    a_dline_align: assert property (@(posedge mclk) disable iff (sys_rst)
        d_take |=> (dm_read && m_rd.addr == ($past(dmiss_addr) & D_MASK)
        && crit_r == 3'h0))
        else $error("data refill not line aligned");

    a_done_all: assert property (@(posedge mclk) disable iff (sys_rst)
        line_done |-> ($past(drain) &&
        $past(drained_r) == $past(nwords_r) - 4'h1 &&
        $past(pushed_r) == $past(nwords_r)))
        else $error("line completed before all words arrived");

    c_icrit: cover property (@(posedge mclk) disable iff (sys_rst)
        i_take && imiss_addr[4:2] != 3'h0);
    c_dfill: cover property (@(posedge mclk) disable iff (sys_rst)
        line_done && line_done_side == CLF_SIDE_D);
    c_ifill: cover property (@(posedge mclk) disable iff (sys_rst)
        line_done && line_done_side == CLF_SIDE_I);
    c_fifo_full: cover property (@(posedge mclk) disable iff (sys_rst)
        m_rvalid && !m_rready);

endmodule // clf_line_fill

// [src/clf_pkg.sv]
// shared constants and types for the cache line fill master
package clf_pkg;

    // word and line geometry
    localparam int CLF_WORD_BYTES = 4;
    localparam int CLF_I_LINE_BYTES = 32;
    localparam int CLF_CACHE_MIN = 512;
    localparam int CLF_CACHE_MAX = 65536;
    localparam int CLF_D_LINE_4 = 4;
    localparam int CLF_D_LINE_16 = 16;
    localparam int CLF_D_LINE_32 = 32;
    localparam int CLF_TCM_MIN = 1;
    localparam int CLF_TCM_MAX = 4;
    localparam int CLF_FIFO_DEPTH = 4;
    localparam int CLF_DATA_W = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] CLF_REG_CTRL = 8'h00;
    localparam logic [7:0] CLF_REG_STATUS = 8'h04;
    localparam logic [7:0] CLF_REG_CFG = 8'h08;

    // control fields
    localparam int CLF_CTRL_IEN = 0;
    localparam int CLF_CTRL_DEN = 1;
    localparam int CLF_CTRL_BURST = 2;
    localparam logic [2:0] CLF_CTRL_RST = 3'h7;

    // status fields
    localparam int CLF_ST_BUSY = 0;
    localparam int CLF_ST_SIDE = 1;
    localparam int CLF_ST_ISSUED = 4;
    localparam int CLF_ST_DRAINED = 8;

    // configuration fields
    localparam int CLF_CFG_IPRES = 0;
    localparam int CLF_CFG_DPRES = 1;
    localparam int CLF_CFG_IMPRES = 2;
    localparam int CLF_CFG_DMPRES = 3;
    localparam int CLF_CFG_IBURST = 4;
    localparam int CLF_CFG_DBURST = 5;
    localparam int CLF_CFG_DWORDS = 8;
    localparam int CLF_CFG_ITCM = 12;
    localparam int CLF_CFG_DTCM = 16;

    // which cache a refill serves
    typedef enum logic {CLF_SIDE_I, CLF_SIDE_D} clf_side_t;

    // read request on the master port
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] burstcount;
    } clf_rd_t;

    // one word written into a cache line
    typedef struct packed {
        clf_side_t side;
        logic [2:0] idx;
        logic [31:0] data;
    } clf_fill_t;

endpackage

// [src/clf_fifo.sv]
// small first-in first-out buffer for returned refill words
`timescale 1ns/1ps
module clf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                        (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r[AW-1:0]];

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule // clf_fifo

// [verif/clf_mem_model.sv]
// memory interconnect model answering refill reads
`timescale 1ns/1ps
module clf_mem_model
    import clf_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic im_read,
    input wire logic dm_read,
    input wire clf_rd_t m_rd,
    input wire logic m_rready,
    input wire logic slow,
    output logic m_wait,
    output logic m_rvalid,
    output logic [31:0] m_rdata
);
    logic [31:0] base_r, last_r, span, beat_addr;
    logic [3:0] left_r, cnt_r, n_r;
    logic gap_r, waited_r, req;

    // slow mode stalls each request for one cycle
    assign req = im_read || dm_read;
    assign m_wait = req && slow && !waited_r;
    assign m_rvalid = (left_r != 4'h0) && !gap_r;
    // beat address wraps inside the burst span, data is the address
    assign span = {26'h0, cnt_r, 2'b00};
    assign beat_addr = (base_r & ~(span - 32'h1)) |
        ((base_r + {26'h0, n_r, 2'b00}) & (span - 32'h1));
    // released bus shows the inverse of the last word
    assign m_rdata = m_rvalid ? beat_addr : ~last_r;

    // request acceptance and beat sequencing, held while not ready
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            left_r <= 4'h0;
            cnt_r <= 4'h1;
            n_r <= 4'h0;
            gap_r <= 1'b0;
            waited_r <= 1'b0;
            base_r <= 32'h0;
            last_r <= 32'h0;
        end else begin
            waited_r <= m_wait;
            gap_r <= m_rvalid && m_rready && slow;
            if (req && !m_wait) begin
                left_r <= m_rd.burstcount;
                cnt_r <= m_rd.burstcount;
                base_r <= m_rd.addr;
                n_r <= 4'h0;
            end else if (m_rvalid && m_rready) begin
                left_r <= left_r - 4'h1;
                n_r <= n_r + 4'h1;
                last_r <= m_rdata;
            end
        end
    end
endmodule // clf_mem_model

// [verif/clf_line_fill_bench.sv]
// self-checking bench for the cache line fill master
`timescale 1ns/1ps
module clf_line_fill_bench
    import clf_pkg::*;
;
    typedef struct {logic side; logic [31:0] addr;
        logic [2:0] ctrl;} clf_row_t;
    logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, imiss_addr = 32'h0, dmiss_addr = 32'h0;
    logic imiss_valid = 1'b0, dmiss_valid = 1'b0, fill_ready = 1'b1;
    logic slow = 1'b0;
    logic [31:0] reg_rdata, m_rdata, d;
    logic imiss_ready, dmiss_ready, im_read, dm_read, m_wait, m_rvalid;
    logic m_rready, fill_valid, line_done;
    logic [3:0] itcm_en, dtcm_en;
    clf_rd_t m_rd;
    clf_fill_t fill;
    clf_side_t line_done_side, done_side;
    logic [36:0] rq[$];
    clf_fill_t fq[$];
    int fails = 0, n_compared = 0, done_n = 0, held_n = 0;
    clf_row_t rows[7] = '{'{1'b0, 32'h100, 3'h7}, '{1'b0, 32'h108, 3'h7},
        '{1'b0, 32'h11c, 3'h7}, '{1'b1, 32'h208, 3'h7},
        '{1'b1, 32'h21c, 3'h7}, '{1'b0, 32'h10c, 3'h3},
        '{1'b1, 32'h204, 3'h3}};

    always #5 mclk = ~mclk;

    clf_line_fill dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .imiss_valid(imiss_valid),
        .imiss_addr(imiss_addr), .imiss_ready(imiss_ready),
        .dmiss_valid(dmiss_valid), .dmiss_addr(dmiss_addr),
        .dmiss_ready(dmiss_ready), .im_read(im_read), .dm_read(dm_read),
        .m_rd(m_rd), .m_wait(m_wait), .m_rvalid(m_rvalid),
        .m_rdata(m_rdata), .m_rready(m_rready), .fill_valid(fill_valid),
        .fill(fill), .fill_ready(fill_ready), .line_done(line_done),
        .line_done_side(line_done_side), .itcm_en(itcm_en),
        .dtcm_en(dtcm_en));

    // one memory model behind the shared master port
    clf_mem_model mem_u (.mclk(mclk), .sys_rst(sys_rst), .im_read(im_read),
        .dm_read(dm_read), .m_rd(m_rd), .m_rready(m_rready), .slow(slow),
        .m_wait(m_wait), .m_rvalid(m_rvalid), .m_rdata(m_rdata));

    // records accepted requests, delivered words and finished lines
    always @(posedge mclk) begin
        if ((im_read || dm_read) && !m_wait)
            rq.push_back({dm_read, m_rd.addr, m_rd.burstcount});
        if (fill_valid && fill_ready)
            fq.push_back(fill);
        if (line_done) begin
            done_n++;
            done_side = line_done_side;
        end
        if (m_rvalid && !m_rready)
            held_n++;
    end

    task automatic check(input string what, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // one miss through to the finished line, then compares the traffic
    task automatic run_miss(input logic side, input logic [31:0] addr,
                            input logic [2:0] ctrl);
        int k, nreq;
        logic [2:0] first, idx;
        logic [31:0] base;
        reg_write(CLF_REG_CTRL, {29'h0, ctrl});
        rq.delete();
        fq.delete();
        done_n = 0;
        first = side ? 3'h0 : addr[4:2];
        base = {addr[31:5], 5'h00};
        nreq = ctrl[CLF_CTRL_BURST] ? 1 : 8;
        @(posedge mclk);
        imiss_valid <= !side;
        dmiss_valid <= side;
        imiss_addr <= addr;
        dmiss_addr <= addr;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (!(side ? dmiss_ready : imiss_ready) && k < 50);
        @(posedge mclk);
        imiss_valid <= 1'b0;
        dmiss_valid <= 1'b0;
        k = 0;
        while (done_n == 0 && k < 600) begin
            @(posedge mclk);
            k++;
        end
        #1;
        check("line done count", done_n, 1);
        check("line side", {31'h0, done_side}, {31'h0, side});
        check("request count", rq.size(), nreq);
        check("fill count", fq.size(), 8);
        for (k = 0; k < 8; k++) begin
            idx = first + k[2:0];
            if (k < nreq && k < rq.size()) begin
                check("req addr", rq[k][35:4], base | {idx, 2'b00});
                check("req burst", rq[k][3:0], nreq == 1 ? 8 : 1);
                check("req master", rq[k][36], side);
            end
            if (k < fq.size()) begin
                check("fill idx", fq[k].idx, idx);
                check("fill data", fq[k].data, base | {idx, 2'b00});
            end
        end
    endtask

    task give_verdict;
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // cuts a hang short
    initial begin
        #200us;
        fails++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        reg_read(CLF_REG_CTRL, d);
        check("ctrl reset", d, 32'h7);
        reg_read(CLF_REG_CFG, d);
        check("config", d, 32'h0001183f);
        reg_read(8'h3c, d);
        check("unmapped", d, 32'h0);
        check("itcm ports", itcm_en, 32'h1);
        check("dtcm ports", dtcm_en, 32'h1);
        foreach (rows[i])
            run_miss(rows[i].side, rows[i].addr, rows[i].ctrl);
        reg_read(CLF_REG_STATUS, d);
        check("status", d, 32'h882);
        // cache stalls while memory is slow: fifo fills and pushes back
        @(posedge mclk);
        slow <= 1'b1;
        fill_ready <= 1'b0;
        held_n = 0;
        fork
            run_miss(1'b0, 32'h304, 3'h7);
            begin
                repeat (40) @(posedge mclk);
                @(negedge mclk);
                check("busy refuses miss", imiss_ready, 1'b0);
                @(posedge mclk);
                fill_ready <= 1'b1;
            end
        join
        check("back pressure", held_n != 0, 1'b1);
        slow <= 1'b0;
        run_miss(1'b1, 32'h31c, 3'h3);
        reg_write(CLF_REG_CTRL, 32'h6);
        @(negedge mclk);
        check("icache off", imiss_ready, 1'b0);
        check("dcache on", dmiss_ready, 1'b1);
        // reset in mid-line drops the refill and restores the defaults
        @(posedge mclk);
        dmiss_addr <= 32'h400;
        dmiss_valid <= 1'b1;
        @(posedge mclk);
        dmiss_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b1;
        #1;
        check("reset read", dm_read, 1'b0);
        check("reset fill", fill_valid, 1'b0);
        check("reset done", line_done, 1'b0);
        check("reset request", m_rd.addr, 32'h0);
        @(posedge mclk);
        sys_rst <= 1'b0;
        reg_read(CLF_REG_CTRL, d);
        check("ctrl after reset", d, 32'h7);
        reg_read(CLF_REG_STATUS, d);
        check("status after reset", d, 32'h0);
        run_miss(1'b0, 32'h114, 3'h7);
        give_verdict;
    end
endmodule // clf_line_fill_bench
